// [logic/dcls_map.vh]
// Purpose: register map, field positions and codes of the line state block
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   policy code 0 is copyback, 1 is write-through
`ifndef DCLS_MAP_VH
`define DCLS_MAP_VH
`define DCLS_CTRL_OFF     8'h00
`define DCLS_REGION_OFF   8'h04
`define DCLS_STATUS_OFF   8'h08
`define DCLS_CTRL_POLICY  0
`define DCLS_CTRL_DFLUSH  1
`define DCLS_CTRL_IFLUSH  2
`define DCLS_RGN_POLICY   2
`define DCLS_RGN_EN       15
`define DCLS_RGN_MASK_LO  16
`define DCLS_RGN_BASE_LO  24
`define DCLS_RGN_FLD_W    8
`define DCLS_CTRL_RST     32'h0000_0000
`define DCLS_RGN_RST      32'h0000_0000
`define DCLS_POL_CB       1'b0
`define DCLS_POL_WT       1'b1
`define DCLS_OP_READ      3'h0
`define DCLS_OP_WRITE     3'h1
`define DCLS_OP_INVAL     3'h2
`define DCLS_OP_PUSH_INV  3'h3
`define DCLS_OP_PUSH_KEEP 3'h4
`define DCLS_WOFF_LO      2
`define DCLS_WAYS         4
`endif

// [logic/dcls_region_match.v]
// Purpose: picks copyback or write-through for one access
// Assumes: region compares the top address byte under a mask
// Notes:   combinational
`timescale 1ns/1ns
`include "dcls_map.vh"
module dcls_region_match (
  input  wire [31:0] addr,
  input  wire [31:0] region_attr_reg,
  input  wire        default_policy_field,
  output wire        write_through
);
  wire [7:0] base = region_attr_reg[`DCLS_RGN_BASE_LO +: `DCLS_RGN_FLD_W];
  wire [7:0] mask = region_attr_reg[`DCLS_RGN_MASK_LO +: `DCLS_RGN_FLD_W];
  wire       hit  = region_attr_reg[`DCLS_RGN_EN] &&
                    (((addr[31:24] ^ base) & ~mask) == 8'h00);
  assign write_through = hit ? region_attr_reg[`DCLS_RGN_POLICY]
                             : default_policy_field;
endmodule

// [logic/dcls_victim_pick.v]
// Purpose: chooses the way to fill on a miss
// Assumes: four ways per set
// Notes:   free line first, else round-robin pointer
`timescale 1ns/1ns
module dcls_victim_pick (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [3:0] live_set,
  input  wire       advance,
  output reg  [1:0] victim
);
  reg [1:0] rr;
  always @* begin
    if (!live_set[0])
      victim = 2'h0;
    else if (!live_set[1])
      victim = 2'h1;
    else if (!live_set[2])
      victim = 2'h2;
    else if (!live_set[3])
      victim = 2'h3;
    else
      victim = rr;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rr <= 2'h0;
    else if (advance && (&live_set))
      rr <= rr + 2'h1;
  end
endmodule

// [logic/dcls_line_state.v]
// Purpose: line state machine of a four-way data cache with APB registers
// Assumes: memory port answers each word with a one-cycle mem_ack
// Notes:   one request at a time; mem_req held until mem_ack
`timescale 1ns/1ns
`include "dcls_map.vh"
module dcls_line_state #(
  parameter SET_BITS  = 2,
  parameter WORD_BITS = 2
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        req_valid,
  output reg         req_ready,
  input  wire [2:0]  req_op,
  input  wire [31:0] req_addr,
  input  wire [31:0] req_wdata,
  output reg         rsp_valid,
  output reg  [31:0] rsp_rdata,
  output reg         mem_req,
  output reg         mem_write,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);
  localparam WORDS  = 1 << WORD_BITS;
  localparam LINES  = (1 << SET_BITS) * `DCLS_WAYS;
  localparam LBITS  = SET_BITS + 2;
  localparam DBITS  = LBITS + WORD_BITS;
  localparam TAG_W  = 32 - `DCLS_WOFF_LO - WORD_BITS - SET_BITS;
  localparam TAG_LO = 32 - TAG_W;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FILL = 3'h1;
  localparam [2:0] ST_RESP = 3'h2;
  localparam [2:0] ST_WB   = 3'h3;
  localparam [2:0] ST_WT   = 3'h4;

  function [LBITS-1:0] lidx;
    input [SET_BITS-1:0] s;
    input [1:0]          w;
    lidx = {s, w};
  endfunction

  function [DBITS-1:0] didx;
    input [SET_BITS-1:0]  s;
    input [1:0]           w;
    input [WORD_BITS-1:0] o;
    didx = {s, w, o};
  endfunction

  reg  [31:0]          cache_ctrl_reg;
  reg  [31:0]          region_attr_reg;
  reg                  flush_pend;
  reg  [LINES-1:0]     live;
  reg  [LINES-1:0]     dirty;
  reg  [TAG_W-1:0]     tag_mem [0:LINES-1];
  reg  [31:0]          data_mem [0:(LINES*WORDS)-1];
  reg  [31:0]          pbuf [0:WORDS-1];
  reg  [TAG_W-1:0]     pb_tag;
  reg                  pb_pend;
  reg  [2:0]           state;
  reg  [2:0]           q_op;
  reg  [SET_BITS-1:0]  q_set;
  reg  [TAG_W-1:0]     q_tag;
  reg  [WORD_BITS-1:0] q_word;
  reg  [31:0]          q_wdata;
  reg  [1:0]           q_way;
  reg                  q_hit;
  reg  [WORD_BITS-1:0] cnt;
  wire [SET_BITS-1:0]  a_set  = req_addr[`DCLS_WOFF_LO+WORD_BITS +: SET_BITS];
  wire [WORD_BITS-1:0] a_word = req_addr[`DCLS_WOFF_LO +: WORD_BITS];
  wire [TAG_W-1:0]     a_tag  = req_addr[TAG_LO +: TAG_W];
  wire [3:0]           hit_vec;
  wire [3:0]           live_set;
  wire                 wt;
  wire [1:0]           victim;
  wire                 hit    = |hit_vec;
  wire [1:0]           hit_way = {hit_vec[3] | hit_vec[2],
                                  hit_vec[3] | hit_vec[1]};
  wire [LBITS-1:0]     h_line = lidx(a_set, hit_way);
  wire [LBITS-1:0]     v_line = lidx(a_set, victim);
  wire [LBITS-1:0]     q_line = lidx(q_set, q_way);
  wire                 accept = (state == ST_IDLE) && req_valid && req_ready;
  wire                 miss_go = accept && !hit &&
                                 ((req_op == `DCLS_OP_READ) ||
                                  ((req_op == `DCLS_OP_WRITE) && !wt));
  wire                 flush_take = (state == ST_IDLE) && !accept &&
                                    flush_pend;
  wire                 last = (cnt == {WORD_BITS{1'b1}});
  wire                 keep = (q_op == `DCLS_OP_PUSH_KEEP);
  wire                 setup = psel && !penable;
  integer              i;

  genvar g;
  generate
    for (g = 0; g < `DCLS_WAYS; g = g + 1) begin : g_way
      assign live_set[g] = live[a_set*`DCLS_WAYS + g];
      assign hit_vec[g]  = live_set[g] &&
                           (tag_mem[a_set*`DCLS_WAYS + g] == a_tag);
    end
  endgenerate

  dcls_region_match u_region (
    .addr                 (req_addr),
    .region_attr_reg      (region_attr_reg),
    .default_policy_field (cache_ctrl_reg[`DCLS_CTRL_POLICY]),
    .write_through        (wt)
  );

  dcls_victim_pick u_victim (
    .pclk     (pclk),
    .presetn  (presetn),
    .live_set (live_set),
    .advance  (miss_go),
    .victim   (victim)
  );

  // apb slave, answers in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_ctrl_reg  <= `DCLS_CTRL_RST;
      region_attr_reg <= `DCLS_RGN_RST;
      flush_pend      <= 1'b0;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      flush_pend <= flush_pend && !flush_take;
      cache_ctrl_reg[`DCLS_CTRL_DFLUSH] <= 1'b0;
      cache_ctrl_reg[`DCLS_CTRL_IFLUSH] <= 1'b0;
      if (setup) begin
        case (paddr)
          `DCLS_CTRL_OFF: begin
            prdata <= cache_ctrl_reg;
            if (pwrite) begin
              cache_ctrl_reg <= pwdata;
              if (pwdata[`DCLS_CTRL_DFLUSH])
                flush_pend <= 1'b1;
            end
          end
          `DCLS_REGION_OFF: begin
            prdata <= region_attr_reg;
            if (pwrite)
              region_attr_reg <= pwdata;
          end
          `DCLS_STATUS_OFF:
            prdata <= {27'h000_0000, flush_pend, pb_pend, state};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // line state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live      <= {LINES{1'b0}};
      dirty     <= {LINES{1'b0}};
      state     <= ST_IDLE;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      pb_tag    <= {TAG_W{1'b0}};
      pb_pend   <= 1'b0;
      q_op      <= `DCLS_OP_READ;
      q_set     <= {SET_BITS{1'b0}};
      q_tag     <= {TAG_W{1'b0}};
      q_word    <= {WORD_BITS{1'b0}};
      q_wdata   <= 32'h0000_0000;
      q_way     <= 2'h0;
      q_hit     <= 1'b0;
      cnt       <= {WORD_BITS{1'b0}};
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= !flush_pend;
          if (accept) begin
            q_op    <= req_op;
            q_set   <= a_set;
            q_tag   <= a_tag;
            q_word  <= a_word;
            q_wdata <= req_wdata;
            q_hit   <= hit;
            q_way   <= hit ? hit_way : victim;
            cnt     <= {WORD_BITS{1'b0}};
            case (req_op)
              `DCLS_OP_READ: begin
                if (hit) begin
                  rsp_rdata <= data_mem[didx(a_set, hit_way, a_word)];
                  rsp_valid <= 1'b1;
                end
              end
              `DCLS_OP_WRITE: begin
                if (wt) begin
                  if (hit)
                    data_mem[didx(a_set, hit_way, a_word)] <= req_wdata;
                  req_ready <= 1'b0;
                  state     <= ST_WT;
                  mem_req   <= 1'b1;
                  mem_write <= 1'b1;
                  mem_addr  <= req_addr;
                  mem_wdata <= req_wdata;
                end else if (hit) begin
                  data_mem[didx(a_set, hit_way, a_word)] <= req_wdata;
                  dirty[h_line] <= 1'b1;
                  rsp_valid     <= 1'b1;
                end
              end
              `DCLS_OP_INVAL: begin
                if (hit) begin
                  live[h_line]  <= 1'b0;
                  dirty[h_line] <= 1'b0;
                end
                rsp_valid <= 1'b1;
              end
              default: begin
                if (hit && dirty[h_line]) begin
                  for (i = 0; i < WORDS; i = i + 1)
                    pbuf[i] <= data_mem[h_line*WORDS + i];
                  pb_tag    <= a_tag;
                  req_ready <= 1'b0;
                  state     <= ST_WB;
                  mem_req   <= 1'b1;
                  mem_write <= 1'b1;
                  mem_addr  <= {a_tag, a_set, {WORD_BITS{1'b0}}, 2'b00};
                  mem_wdata <= data_mem[h_line*WORDS];
                end else begin
                  if (hit && (req_op != `DCLS_OP_PUSH_KEEP))
                    live[h_line] <= 1'b0;
                  rsp_valid <= 1'b1;
                end
              end
            endcase
            if (miss_go) begin
              if (live[v_line] && dirty[v_line]) begin
                for (i = 0; i < WORDS; i = i + 1)
                  pbuf[i] <= data_mem[v_line*WORDS + i];
                pb_tag  <= tag_mem[v_line];
                pb_pend <= 1'b1;
              end
              live[v_line]    <= 1'b0;
              dirty[v_line]   <= 1'b0;
              tag_mem[v_line] <= a_tag;
              req_ready <= 1'b0;
              state     <= ST_FILL;
              mem_req   <= 1'b1;
              mem_write <= 1'b0;
              mem_addr  <= {a_tag, a_set, {WORD_BITS{1'b0}}, 2'b00};
            end
          end else if (flush_take) begin
            live  <= {LINES{1'b0}};
            dirty <= {LINES{1'b0}};
          end
        end
        ST_FILL: begin
          if (mem_ack) begin
            data_mem[didx(q_set, q_way, cnt)] <=
              ((q_op == `DCLS_OP_WRITE) && (cnt == q_word)) ?
              q_wdata : mem_rdata;
            if (cnt == q_word)
              rsp_rdata <= mem_rdata;
            cnt <= cnt + {{(WORD_BITS-1){1'b0}}, 1'b1};
            mem_addr <= {q_tag, q_set, cnt + {{(WORD_BITS-1){1'b0}}, 1'b1},
                         2'b00};
            if (last) begin
              mem_req <= 1'b0;
              state   <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          live[q_line] <= 1'b1;
          dirty[q_line] <= (q_op == `DCLS_OP_WRITE);
          rsp_valid <= 1'b1;
          cnt       <= {WORD_BITS{1'b0}};
          if (pb_pend) begin
            state     <= ST_WB;
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_addr  <= {pb_tag, q_set, {WORD_BITS{1'b0}}, 2'b00};
            mem_wdata <= pbuf[0];
          end else begin
            state     <= ST_IDLE;
            req_ready <= !flush_pend;
          end
        end
        ST_WB: begin
          if (mem_ack) begin
            cnt <= cnt + {{(WORD_BITS-1){1'b0}}, 1'b1};
            mem_addr <= {pb_tag, q_set, cnt + {{(WORD_BITS-1){1'b0}}, 1'b1},
                         2'b00};
            mem_wdata <= pbuf[cnt + {{(WORD_BITS-1){1'b0}}, 1'b1}];
            if (last) begin
              mem_req   <= 1'b0;
              mem_write <= 1'b0;
              pb_pend   <= 1'b0;
              state     <= ST_IDLE;
              req_ready <= !flush_pend;
              if (!pb_pend) begin
                live[q_line]  <= keep;
                dirty[q_line] <= 1'b0;
                rsp_valid     <= 1'b1;
              end
            end
          end
        end
        ST_WT: begin
          if (mem_ack) begin
            if (q_hit)
              dirty[q_line] <= 1'b0;
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            rsp_valid <= 1'b1;
            state     <= ST_IDLE;
            req_ready <= !flush_pend;
          end
        end
        default: begin
          state     <= ST_IDLE;
          mem_req   <= 1'b0;
          req_ready <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [testbench/dcls_monitor.sv]
// Purpose: port checks on the data cache line state block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every instance of the block
`timescale 1ns/1ns
`include "dcls_map.vh"
module dcls_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        req_valid,
  input wire        req_ready,
  input wire [2:0]  req_op,
  input wire        rsp_valid,
  input wire        mem_req,
  input wire        mem_write,
  input wire [31:0] mem_addr,
  input wire        mem_ack
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_quick;
    rsp_valid && !mem_req;
  endsequence
  sequence s_fill_last;
    mem_req && mem_ack && !mem_write && mem_addr[3:2] == 2'h3;
  endsequence
  property p_inval;
    s_take ##0 (req_op == `DCLS_OP_INVAL) |=> s_quick;
  endproperty
  a_inval: assert property (p_inval)
    else $error("invalidate used memory");
  property p_read;
    s_take ##0 (req_op == `DCLS_OP_READ) |=> s_quick or (mem_req && !mem_write);
  endproperty
  a_read: assert property (p_read)
    else $error("read did not answer or fill first");
  property p_push;
    s_take ##0 (req_op == `DCLS_OP_PUSH_INV || req_op == `DCLS_OP_PUSH_KEEP)
      |=> s_quick or (mem_req && mem_write);
  endproperty
  a_push: assert property (p_push)
    else $error("push neither answered nor wrote");
  property p_write;
    s_take ##0 (req_op == `DCLS_OP_WRITE) |=> s_quick or mem_req;
  endproperty
  a_write: assert property (p_write)
    else $error("write neither answered nor used memory");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write);
  endproperty
  a_hold: assert property (p_hold)
    else $error("memory request changed before ack");
  property p_align;
    mem_req |-> mem_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("memory address not word aligned");
  property p_ascend;
    mem_req && mem_ack && !mem_write && mem_addr[3:2] != 2'h3
      |=> mem_req && !mem_write && mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("line fill not ascending");
  property p_fill_end;
    s_fill_last |=> !mem_req ##1 rsp_valid;
  endproperty
  a_fill_end: assert property (p_fill_end)
    else $error("no answer after line fill");
  property p_busy;
    mem_req |-> !req_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("request taken while memory busy");
  property p_apb;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("register access answer wrong");
endmodule
bind dcls_line_state dcls_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .req_valid(req_valid), .req_ready(req_ready),
  .req_op(req_op), .rsp_valid(rsp_valid), .mem_req(mem_req),
  .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack)
);

// [testbench/dcls_mem_model.sv]
// Purpose: word memory behind the cache, prompt or slow
// Assumes: one word per ack, 256 words aliased
// Notes:   read data churns when not acknowledged
`timescale 1ns/1ns
module dcls_mem_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         slow,
  input  wire         mem_req,
  input  wire         mem_write,
  input  wire  [31:0] mem_addr,
  input  wire  [31:0] mem_wdata,
  output logic        mem_ack,
  output logic [31:0] mem_rdata,
  output int          n_rd,
  output int          n_wr
);
  logic [31:0] ram [0:255];
  logic        gap;
  initial for (int i = 0; i < 256; i++) ram[i] = 32'h5a00_0000 + i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      gap <= 1'b0;
      n_rd <= 0;
      n_wr <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      gap <= slow & ~gap;
      if (mem_req && !mem_ack && !gap) begin
        mem_ack <= 1'b1;
        if (mem_write) begin
          ram[mem_addr[9:2]] <= mem_wdata;
          n_wr <= n_wr + 1;
        end else begin
          mem_rdata <= ram[mem_addr[9:2]];
          n_rd <= n_rd + 1;
        end
      end
    end
  end
endmodule

// [testbench/dcls_line_state_tb.sv]
// Purpose: self-checking bench of the data cache line state block
// Assumes: memory model counts word reads and writes
// Notes:   expected data derive from the model's initial pattern
`timescale 1ns/1ns
`include "dcls_map.vh"
module dcls_line_state_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        req_valid, req_ready, rsp_valid, slow;
  logic        mem_req, mem_write, mem_ack;
  logic [7:0]  paddr;
  logic [2:0]  req_op;
  logic [31:0] pwdata, prdata, req_addr, req_wdata, rsp_rdata, got;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  int          n_rd, n_wr, n_fail, tests_run;
  localparam logic [2:0] RD = `DCLS_OP_READ;
  localparam logic [2:0] WR = `DCLS_OP_WRITE;
  localparam logic [2:0] IV = `DCLS_OP_INVAL;
  localparam logic [2:0] PI = `DCLS_OP_PUSH_INV;
  localparam logic [2:0] PK = `DCLS_OP_PUSH_KEEP;
  dcls_line_state uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  dcls_mem_model mem (
    .pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .n_rd(n_rd), .n_wr(n_wr));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pready;
      1: return req_ready;
      default: return rsp_valid;
    endcase
  endfunction
  task automatic wt(input int w);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (sig(w) !== 1'b1 && k < 300);
    if (sig(w) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t handshake timeout", $time);
      end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wt(0);
    got = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] o, input logic [31:0] a, d,
                     input int er, ew);
    int r0;
    int w0;
    r0 = n_rd;
    w0 = n_wr;
    @(posedge pclk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_wdata <= d;
    wt(1);
    req_valid <= 1'b0;
    wt(2);
    got = rsp_rdata;
    wt(1);
    chk(n_rd - r0, er);
    chk(n_wr - w0, ew);
  endtask
  function automatic logic [31:0] mv(input logic [31:0] a);
    return 32'h5a00_0000 + a[9:2];
  endfunction
  task automatic t_regs();
    apb(1'b0, `DCLS_CTRL_OFF, 32'h0);
    chk(got, `DCLS_CTRL_RST);
    apb(1'b0, 8'h0c, 32'h0);
    chk({got[30:0], err}, 32'h1);
    apb(1'b1, `DCLS_REGION_OFF, 32'h0100_8004);
    apb(1'b0, `DCLS_REGION_OFF, 32'h0);
    chk(got, 32'h0100_8004);
    apb(1'b0, `DCLS_STATUS_OFF, 32'h0);
    chk(got, 32'h0);
    $display("registers done");
  endtask
  task automatic t_read();
    run(RD, 32'h104, 0, 4, 0);
    chk(got, mv(32'h104));
    run(RD, 32'h104, 0, 0, 0);
    chk(got, mv(32'h104));
    $display("read done");
  endtask
  task automatic t_cb();
    run(WR, 32'h108, 32'hc0de_0001, 0, 0);
    run(PK, 32'h100, 0, 0, 4);
    run(PK, 32'h100, 0, 0, 0);
    run(RD, 32'h108, 0, 0, 0);
    chk(got, 32'hc0de_0001);
    run(PI, 32'h100, 0, 0, 0);
    run(PI, 32'h100, 0, 0, 0);
    run(RD, 32'h108, 0, 4, 0);
    chk(got, 32'hc0de_0001);
    $display("copyback done");
  endtask
  task automatic t_inval();
    run(WR, 32'h200, 32'h0bad_0002, 4, 0);
    run(RD, 32'h200, 0, 0, 0);
    chk(got, 32'h0bad_0002);
    run(IV, 32'h200, 0, 0, 0);
    run(RD, 32'h200, 0, 4, 0);
    chk(got, mv(32'h200));
    $display("invalidate done");
  endtask
  task automatic t_victim();
    slow <= 1'b1;
    for (int i = 0; i < 4; i++)
      run(WR, 32'h010 + i * 64, 32'hd0 + i, 4, 0);
    run(RD, 32'h110, 0, 4, 4);
    chk(got, mv(32'h110));
    run(WR, 32'h150, 32'h5eed_0003, 4, 4);
    run(PK, 32'h150, 0, 0, 4);
    slow <= 1'b0;
    $display("victim done");
  endtask
  task automatic t_wt();
    apb(1'b1, `DCLS_CTRL_OFF, 32'h6);
    apb(1'b0, `DCLS_CTRL_OFF, 32'h0);
    chk(got, 32'h0);
    run(RD, 32'h100, 0, 4, 0);
    apb(1'b1, `DCLS_CTRL_OFF, 32'h1);
    run(WR, 32'h300, 32'h1, 0, 1);
    run(RD, 32'h300, 0, 4, 0);
    chk(got, 32'h1);
    run(WR, 32'h300, 32'h2, 0, 1);
    run(RD, 32'h300, 0, 0, 0);
    chk(got, 32'h2);
    apb(1'b1, `DCLS_CTRL_OFF, 32'h0);
    run(WR, 32'h300, 32'h3, 0, 0);
    apb(1'b1, `DCLS_REGION_OFF, 32'h0000_8004);
    run(WR, 32'h3c0, 32'h4, 0, 1);
    run(WR, 32'h300, 32'h5, 0, 1);
    run(PK, 32'h300, 0, 0, 0);
    apb(1'b1, `DCLS_REGION_OFF, 32'h0100_8004);
    run(WR, 32'h300, 32'h6, 0, 0);
    $display("write-through done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, req_valid, slow} = 6'h0;
    paddr = 8'h0;
    req_op = 3'h0;
    {pwdata, req_addr, req_wdata} = 96'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_read();
    t_cb();
    t_inval();
    t_victim();
    t_wt();
    end_of_test();
  end
endmodule
